/* File: rtl/timer_pkg.sv */
// Purpose: constants shared by the clock timer and stopwatch block
// Assumes: 4-bit registers sit in the low bits of 32-bit APB words
// Notes: printed offsets are register indices, byte address is index * 4
package timer_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CLK_CTRL = 16'hFF78;
  localparam logic [15:0] IDX_CLK_LOW = 16'hFF79;
  localparam logic [15:0] IDX_CLK_HIGH = 16'hFF7A;
  localparam logic [15:0] IDX_SW_CTRL = 16'hFF7C;
  localparam logic [15:0] IDX_SW_HUND = 16'hFF7D;
  localparam logic [15:0] IDX_SW_TENTH = 16'hFF7E;
  localparam logic [15:0] IDX_CLK_EN = 16'hFFE6;
  localparam logic [15:0] IDX_SW_EN = 16'hFFE7;
  localparam logic [15:0] IDX_CLK_FLAGS = 16'hFFF6;
  localparam logic [15:0] IDX_SW_FLAGS = 16'hFFF7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam int TAP_32HZ = 2;
  localparam int TAP_8HZ = 4;
  localparam int TAP_2HZ = 6;
  localparam int TAP_1HZ = 7;
  localparam int SW_F10 = 0;
  localparam int SW_F1 = 1;

  // ---------------------------------------------------------------
  // values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_FULL = 4'hF;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [1:0] STEP_LONG = 2'h3;
  localparam logic [1:0] STEP_SHORT = 2'h2;
  localparam logic [3:0] LONG_STEPS_25 = 4'h5;
  localparam logic [3:0] LONG_STEPS_26 = 4'h6;
  localparam int PCLK_HZ = 20_000_000;
  localparam int BASE_HZ = 256;
  localparam int HOLD_NS = 1_000_000;
  localparam int BASE_CYCLES = PCLK_HZ / BASE_HZ;
  localparam int HOLD_CYCLES = HOLD_NS / (1_000_000_000 / PCLK_HZ);

  typedef enum logic [1:0] {
    HOLD_OFF = 2'b01,
    HOLD_ON = 2'b10
  } hold_state_e;

endpackage

/* File: rtl/clock_stopwatch_timers.sv */
// Purpose: clock timer and stopwatch timer behind an APB slave
// Assumes: one clock; the 256 Hz base is divided down from pclk
// Notes: pready is always high, reads are captured in the setup cycle
`timescale 1ns/10ps
module clock_stopwatch_timers
  import timer_pkg::*;
#(
  parameter int BASE_CYCLES_P = BASE_CYCLES,
  parameter int HOLD_CYCLES_P = HOLD_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt requests
  output logic clock_irq,
  output logic stopwatch_irq
);

  localparam int BW = $clog2(BASE_CYCLES_P + 1);
  localparam int HW = $clog2(HOLD_CYCLES_P + 1);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // short decades (25 ticks) fall on tenths 1,3,5,7; the rest take 26
  function automatic logic [1:0] step_len(input logic [3:0] hund, input logic [3:0] tenth);
    logic [3:0] long_steps;
    long_steps = (tenth[0] && tenth != BCD_MAX) ? LONG_STEPS_25 : LONG_STEPS_26;
    return (hund < long_steps) ? STEP_LONG : STEP_SHORT;
  endfunction

  logic setup_rd;
  logic wr_acc;
  logic mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite;
  assign mapped = hit(paddr, IDX_CLK_CTRL) | hit(paddr, IDX_CLK_LOW) |
                  hit(paddr, IDX_CLK_HIGH) | hit(paddr, IDX_SW_CTRL) |
                  hit(paddr, IDX_SW_HUND) | hit(paddr, IDX_SW_TENTH) |
                  hit(paddr, IDX_CLK_EN) | hit(paddr, IDX_SW_EN) |
                  hit(paddr, IDX_CLK_FLAGS) | hit(paddr, IDX_SW_FLAGS);

  // ---------------------------------------------------------------
  // 256 Hz base divider
  // ---------------------------------------------------------------
  logic [BW-1:0] base_cnt;
  logic base_tick;
  assign base_tick = base_cnt == BW'(BASE_CYCLES_P - 1);

  // free running, so run/stop never shifts the base phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt <= '0;
    end else if (base_tick) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= base_cnt + BW'(1);
    end
  end

  // ---------------------------------------------------------------
  // clock timer control
  // ---------------------------------------------------------------
  logic ct_run;
  logic ct_clear;
  logic [3:0] ct_en;
  assign ct_clear = wr_acc & hit(paddr, IDX_CLK_CTRL) & pwdata[CLEAR_BIT];

  // run bit and enables, plain read/write storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ct_run <= 1'b0;
      ct_en <= NIB_ZERO;
    end else begin
      if (wr_acc && hit(paddr, IDX_CLK_CTRL)) begin
        ct_run <= pwdata[RUN_BIT];
      end
      if (wr_acc && hit(paddr, IDX_CLK_EN)) begin
        ct_en <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // high nibble hold
  // ---------------------------------------------------------------
  hold_state_e hold_state;
  logic [HW-1:0] hold_cnt;
  logic held;
  // the read that starts the hold also blocks a carry in its own cycle
  assign held = (hold_state == HOLD_ON) | (setup_rd & hit(paddr, IDX_CLK_LOW));

  // hold ends on the high read or when the window runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_state <= HOLD_OFF;
      hold_cnt <= '0;
    end else begin
      case (hold_state)
        HOLD_OFF: begin
          if (setup_rd && hit(paddr, IDX_CLK_LOW)) begin
            hold_state <= HOLD_ON;
            hold_cnt <= HW'(HOLD_CYCLES_P - 1);
          end
        end
        HOLD_ON: begin
          if ((setup_rd && hit(paddr, IDX_CLK_HIGH)) || hold_cnt == '0 || ct_clear) begin
            hold_state <= HOLD_OFF;
          end else begin
            hold_cnt <= hold_cnt - HW'(1);
          end
        end
        default: begin
          hold_state <= HOLD_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock timer counter
  // ---------------------------------------------------------------
  logic [3:0] count_low;
  logic [3:0] count_high;
  logic carry_pending;
  logic [3:0] next_low;
  logic [3:0] next_high;
  logic next_pending;
  logic ct_step;
  logic low_carry;
  logic [7:0] tap_fall;
  logic [3:0] ct_events;
  assign ct_step = ct_run & base_tick;
  assign low_carry = ct_step & (count_low == NIB_FULL);

  // a carry that lands in the hold is parked and applied on release
  always_comb begin
    next_low = count_low;
    next_high = count_high;
    next_pending = carry_pending;
    if (ct_clear) begin
      next_low = NIB_ZERO;
      next_high = NIB_ZERO;
      next_pending = 1'b0;
    end else begin
      if (ct_step) begin
        next_low = count_low + 4'h1;
      end
      if ((low_carry || carry_pending) && !held) begin
        next_high = count_high + 4'h1;
        next_pending = 1'b0;
      end else if (low_carry) begin
        next_pending = 1'b1;
      end
    end
  end

  // clearing is not a tap edge, so it never raises a flag
  assign tap_fall = {count_high, count_low} & ~{next_high, next_low} & {8{~ct_clear}};
  assign ct_events = {tap_fall[TAP_1HZ], tap_fall[TAP_2HZ], tap_fall[TAP_8HZ],
                      tap_fall[TAP_32HZ]};

  // counter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low <= NIB_ZERO;
      count_high <= NIB_ZERO;
      carry_pending <= 1'b0;
    end else begin
      count_low <= next_low;
      count_high <= next_high;
      carry_pending <= next_pending;
    end
  end

  // ---------------------------------------------------------------
  // stopwatch control and counter
  // ---------------------------------------------------------------
  logic sw_run;
  logic sw_clear;
  logic [1:0] sw_en;
  logic [3:0] hund;
  logic [3:0] tenth;
  logic [1:0] sub;
  logic sw_tick;
  logic step_done;
  logic hund_wrap;
  logic tenth_wrap;
  assign sw_clear = wr_acc & hit(paddr, IDX_SW_CTRL) & pwdata[CLEAR_BIT];
  assign sw_tick = sw_run & base_tick;
  assign step_done = sw_tick & (sub == step_len(hund, tenth) - 2'h1);
  assign hund_wrap = step_done & (hund == BCD_MAX);
  assign tenth_wrap = hund_wrap & (tenth == BCD_MAX);

  // run bit and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_run <= 1'b0;
      sw_en <= 2'h0;
    end else begin
      if (wr_acc && hit(paddr, IDX_SW_CTRL)) begin
        sw_run <= pwdata[RUN_BIT];
      end
      if (wr_acc && hit(paddr, IDX_SW_EN)) begin
        sw_en <= pwdata[1:0];
      end
    end
  end

  // cascaded BCD digits; the clear write also loads run from bit 0, so writing 3 restarts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hund <= NIB_ZERO;
      tenth <= NIB_ZERO;
      sub <= 2'h0;
    end else if (sw_clear) begin
      hund <= NIB_ZERO;
      tenth <= NIB_ZERO;
      sub <= 2'h0;
    end else if (step_done) begin
      sub <= 2'h0;
      hund <= (hund == BCD_MAX) ? NIB_ZERO : hund + 4'h1;
      if (hund_wrap) begin
        tenth <= (tenth == BCD_MAX) ? NIB_ZERO : tenth + 4'h1;
      end
    end else if (sw_tick) begin
      sub <= sub + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags and requests
  // ---------------------------------------------------------------
  logic [3:0] ct_flags;
  logic [1:0] sw_flags;
  logic [3:0] ct_w1c;
  logic [1:0] sw_w1c;
  assign ct_w1c = (wr_acc && hit(paddr, IDX_CLK_FLAGS)) ? pwdata[3:0] : NIB_ZERO;
  assign sw_w1c = (wr_acc && hit(paddr, IDX_SW_FLAGS)) ? pwdata[1:0] : 2'h0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ct_flags <= NIB_ZERO;
      sw_flags <= 2'h0;
    end else begin
      ct_flags <= (ct_flags & ~ct_w1c) | ct_events;
      sw_flags <= (sw_flags & ~sw_w1c) | {tenth_wrap, hund_wrap};
    end
  end

  // level requests; they stay up until software clears the flag
  assign clock_irq = |(ct_flags & ct_en);
  assign stopwatch_irq = |(sw_flags & sw_en);

  // ---------------------------------------------------------------
  // apb read path
  // ---------------------------------------------------------------
  logic [3:0] read_nib;

  // write-only clear bits and unused bits read as zero
  always_comb begin
    read_nib = NIB_ZERO;
    if (hit(paddr, IDX_CLK_CTRL)) begin
      read_nib = {3'h0, ct_run};
    end else if (hit(paddr, IDX_CLK_LOW)) begin
      read_nib = count_low;
    end else if (hit(paddr, IDX_CLK_HIGH)) begin
      read_nib = count_high;
    end else if (hit(paddr, IDX_SW_CTRL)) begin
      read_nib = {3'h0, sw_run};
    end else if (hit(paddr, IDX_SW_HUND)) begin
      read_nib = hund;
    end else if (hit(paddr, IDX_SW_TENTH)) begin
      read_nib = tenth;
    end else if (hit(paddr, IDX_CLK_EN)) begin
      read_nib = ct_en;
    end else if (hit(paddr, IDX_SW_EN)) begin
      read_nib = {2'h0, sw_en};
    end else if (hit(paddr, IDX_CLK_FLAGS)) begin
      read_nib = ct_flags;
    end else if (hit(paddr, IDX_SW_FLAGS)) begin
      read_nib = {2'h0, sw_flags};
    end
  end

  // captured in the setup cycle so the hold and the data agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : {28'h000_0000, read_nib};
      pslverr <= ~mapped;
    end
  end

  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stopped_write_low;
    wr_acc && hit(paddr, IDX_CLK_LOW) && !ct_run && !ct_clear && !carry_pending;
  endsequence
  sequence s_hund_roll;
    step_done && hund == BCD_MAX;
  endsequence

  property p_tap_ro;
    s_stopped_write_low |=> $stable({count_high, count_low});
  endproperty
  a_tap_ro: assert property (p_tap_ro) else $error("clock count moved on write");

  property p_hold_carry;
    held && low_carry && !ct_clear |=> count_high == $past(count_high) && carry_pending;
  endproperty
  a_hold_carry: assert property (p_hold_carry) else $error("carry passed hold");

  property p_clear;
    ct_clear |=> count_low == NIB_ZERO && count_high == NIB_ZERO;
  endproperty
  a_clear: assert property (p_clear) else $error("clock clear failed");

  property p_stop_hold;
    (!ct_run && !ct_clear && !wr_acc) [*2] |-> $stable(count_low);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped count moved");

  property p_fall_32;
    !$past(ct_clear) && $fell(count_low[TAP_32HZ]) |-> ct_flags[0];
  endproperty
  a_fall_32: assert property (p_fall_32) else $error("32 Hz flag missing");

  property p_w1c;
    wr_acc && hit(paddr, IDX_CLK_FLAGS) && pwdata[3] && !ct_events[3] |=> !ct_flags[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("1 Hz flag not cleared");

  property p_irq;
    ct_flags[1] && ct_en[1] |-> clock_irq ##1 (ct_flags[1] && ct_en[1]) [*1] |-> clock_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("clock request dropped");

  property p_roll_10;
    s_hund_roll and !sw_clear |=> hund == NIB_ZERO && sw_flags[SW_F10];
  endproperty
  a_roll_10: assert property (p_roll_10) else $error("10 Hz rollover wrong");

  property p_roll_1;
    tenth_wrap && !sw_clear |=> tenth == NIB_ZERO && sw_flags[SW_F1];
  endproperty
  a_roll_1: assert property (p_roll_1) else $error("1 Hz rollover wrong");

  property p_step;
    sub < STEP_LONG && sub < step_len(hund, tenth);
  endproperty
  a_step: assert property (p_step) else $error("step counter overran");

  property p_sw_clear;
    sw_clear |=> hund == NIB_ZERO && tenth == NIB_ZERO && sub == 2'h0;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("stopwatch clear failed");

  property p_ctrl_read;
    setup_rd && hit(paddr, IDX_SW_CTRL) |=> prdata[31:1] == 31'h0000_0000;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control upper bits set");

endmodule

/* File: test/clock_and_stopwatch_timers_tb.sv */
// Purpose: self-checking bench for the clock timer and stopwatch block
// Assumes: base tick every 4 pclk cycles, so one second is 1024 cycles
// Notes: counts are read only while stopped, since the divider phase is free
`timescale 1ns/10ps
module clock_and_stopwatch_timers_tb
  import timer_pkg::*;
;
  localparam int BC = 4;
  localparam int HC = 40;
  localparam int TAPS[4] = '{TAP_32HZ, TAP_8HZ, TAP_2HZ, TAP_1HZ};
  localparam logic [15:0] REGS[10] = '{IDX_CLK_CTRL, IDX_CLK_LOW, IDX_CLK_HIGH,
    IDX_SW_CTRL, IDX_SW_HUND, IDX_SW_TENTH, IDX_CLK_EN, IDX_SW_EN, IDX_CLK_FLAGS,
    IDX_SW_FLAGS};
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clock_irq;
  logic stopwatch_irq;
  logic [31:0] rd;
  logic serr;
  int n_errors;
  int checks_done;
  // behavioural model state
  int cnt, cfl, cen, hund, tenth, sub, step, sfl, sen, m;

  clock_stopwatch_timers #(.BASE_CYCLES_P(BC), .HOLD_CYCLES_P(HC)) clock_stopwatch_timers_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_irq(clock_irq), .stopwatch_irq(stopwatch_irq));

  // --------------------------------------------------------------
  // compare, bus and model tasks
  // --------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after an edge; an idle cycle follows so
  // back-to-back calls never assign psel twice in one time step
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [15:0] idx, input int exp, input string what);
    apb(1'b0, idx, $urandom);
    chk_word(what, 32'(exp), rd);
    chk_bit({what, " slverr"}, 1'b0, serr);
    chk_bit({what, " pready"}, 1'b1, pready);
  endtask

  // advance the model by n base ticks of one unit
  task automatic adv(input int is_sw, input int n);
    int old;
    repeat (n) begin
      if (is_sw == 0) begin
        old = cnt;
        cnt = (cnt + 1) % 256;
        for (int j = 0; j < 4; j++) begin
          if (old[TAPS[j]] && !cnt[TAPS[j]]) cfl |= 1 << j;
        end
      end else begin
        sub++;
        // odd tenths below 9 give a 25-tick decade (5 long steps), others 26
        if (sub == ((step < ((tenth % 2 == 1 && tenth < 9) ? 5 : 6)) ? 3 : 2)) begin
          sub = 0;
          step++;
          hund++;
          if (hund == 10) begin
            hund = 0;
            step = 0;
            sfl |= 1;
            tenth++;
            if (tenth == 10) begin
              tenth = 0;
              sfl |= 2;
            end
          end
        end
      end
    end
  endtask

  // run a unit for exactly n ticks: the run window spans 4n edges
  task automatic run(input int is_sw, input int n);
    logic [15:0] idx;
    idx = is_sw ? IDX_SW_CTRL : IDX_CLK_CTRL;
    apb(1'b1, idx, 32'h1);
    repeat (4 * n - 3) @(posedge pclk);
    apb(1'b1, idx, 32'h0);
    adv(is_sw, n);
  endtask

  task automatic chk_irq();
    chk_bit("clock_irq", (cfl & cen) != 0, clock_irq);
    chk_bit("stopwatch_irq", (sfl & sen) != 0, stopwatch_irq);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // the tests need at most about 7100 cycles; a hang is cut off well after that
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    {n_errors, checks_done, cnt, cfl, cen, hund, tenth, sub, step, sfl, sen} = '0;
    void'($urandom(32'h9A49));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) rdc(REGS[i], 0, "reset value");
    apb(1'b0, 16'hFF7B, 32'h0);
    chk_bit("unmapped slverr", 1'b1, serr);
    chk_word("unmapped read", 32'h0, rd);
    // enables are plain read/write, stopwatch keeps only two bits
    cen = $urandom_range(1, 15);
    sen = $urandom_range(1, 15);
    apb(1'b1, IDX_CLK_EN, cen);
    rdc(IDX_CLK_EN, cen, "clock enables");
    apb(1'b1, IDX_SW_EN, sen);
    sen &= 3;
    rdc(IDX_SW_EN, sen, "stopwatch enables");
    // clock count, ignored data writes, flags and request
    run(0, 15);
    apb(1'b1, IDX_CLK_LOW, 32'hA);
    rdc(IDX_CLK_LOW, cnt & 15, "count low");
    rdc(IDX_CLK_HIGH, cnt >> 4, "count high");
    rdc(IDX_CLK_FLAGS, cfl, "clock flags");
    chk_irq();
    // carry into the high nibble is held until the high read
    apb(1'b0, IDX_CLK_LOW, 32'h0);
    run(0, 1);
    rdc(IDX_CLK_HIGH, 0, "held high");
    rdc(IDX_CLK_HIGH, cnt >> 4, "released high");
    rdc(IDX_CLK_LOW, cnt & 15, "low after carry");
    // and the hold also runs out on its own
    run(0, 15);
    apb(1'b0, IDX_CLK_LOW, 32'h0);
    run(0, 1);
    repeat (HC + 10) @(posedge pclk);
    rdc(IDX_CLK_HIGH, cnt >> 4, "expired hold");
    // long random runs resume from the kept count, then a random mask of flags is cleared
    for (int i = 0; i < 2; i++) begin
      run(0, $urandom_range(100, 400));
      rdc(IDX_CLK_LOW, cnt & 15, "count low");
      rdc(IDX_CLK_HIGH, cnt >> 4, "count high");
      rdc(IDX_CLK_FLAGS, cfl, "clock flags");
      chk_irq();
      m = $urandom_range(0, 15);
      apb(1'b1, IDX_CLK_FLAGS, m);
      cfl &= ~m;
      rdc(IDX_CLK_FLAGS, cfl, "flags after clear");
      chk_irq();
    end
    // clear while stopped holds zero, clear while running restarts at once
    apb(1'b1, IDX_CLK_CTRL, 32'h2);
    rdc(IDX_CLK_CTRL, 0, "clock control");
    rdc(IDX_CLK_LOW, 0, "cleared low");
    rdc(IDX_CLK_HIGH, 0, "cleared high");
    cnt = 0;
    apb(1'b1, IDX_CLK_CTRL, 32'h3);
    rdc(IDX_CLK_CTRL, 1, "clock control running");
    repeat (6) @(posedge pclk);
    apb(1'b1, IDX_CLK_CTRL, 32'h0);
    adv(0, 3);
    rdc(IDX_CLK_LOW, cnt, "restarted count");
    rdc(IDX_CLK_FLAGS, cfl, "flags after clear");
    // stopwatch: one full second, then random segments
    run(1, 256);
    rdc(IDX_SW_HUND, hund, "hundredths");
    rdc(IDX_SW_TENTH, tenth, "tenths");
    rdc(IDX_SW_FLAGS, sfl, "stopwatch flags");
    chk_irq();
    for (int i = 0; i < 3; i++) begin
      run(1, $urandom_range(1, 200));
      apb(1'b1, IDX_SW_HUND, 32'h5);
      rdc(IDX_SW_HUND, hund, "hundredths");
      rdc(IDX_SW_TENTH, tenth, "tenths");
      m = $urandom_range(0, 3);
      apb(1'b1, IDX_SW_FLAGS, m);
      sfl &= ~m;
      rdc(IDX_SW_FLAGS, sfl, "stopwatch flags");
      chk_irq();
    end
    apb(1'b1, IDX_SW_CTRL, 32'h2);
    rdc(IDX_SW_CTRL, 0, "stopwatch control");
    rdc(IDX_SW_HUND, 0, "cleared hundredths");
    rdc(IDX_SW_TENTH, 0, "cleared tenths");
    // clear while running: the run window below spans exactly 5 ticks
    {hund, tenth, sub, step} = '0;
    apb(1'b1, IDX_SW_CTRL, 32'h3);
    rdc(IDX_SW_CTRL, 1, "stopwatch running");
    repeat (14) @(posedge pclk);
    apb(1'b1, IDX_SW_CTRL, 32'h0);
    adv(1, 5);
    rdc(IDX_SW_HUND, hund, "restarted hundredths");
    rdc(IDX_SW_TENTH, tenth, "restarted tenths");
    test_done();
  end
endmodule
